// ### mscr_cfg.svh
// Summary of operation
// - Start-up word at index 86h, 32 bits, resets zero, bit 31 reads zero.
// - Bits 30..27 pick one of sixteen open-loop current caps, 0.078125 A to 5.0 A.
// - Open-loop cap field applies only while source select is zero, else general cap.
// - Bits 26..23 pick the linear open-loop acceleration, 0.01 to 10000 Hz/s.
// - Bits 22..19 pick the quadratic open-loop acceleration, 0.0 to 10000 Hz/s2.
// - Bit 18 set gives automatic handoff; clear uses the programmed threshold.
// - Bits 17..13 give threshold: 1% steps to 20%, then 2.5% steps to 50%.
// - Bits 12..8 pick the alignment angle, code zero is 0 deg, top codes reserved.
// - Bits 7..4 set first-cycle frequency, 1% to 50% of maximum speed.
// - Bit 3 picks first open-loop cycle rate: zero gives 0 Hz, one gives field.
// - Bits 2..0 set theta error ramp rate, 0.01 to 2 deg/ms.
// - Closed-loop word at index 88h, 32 bits, resets zero, bit 31 reads zero.
// - Closed-loop bit 30 enables overmodulation; reset leaves it disabled.
`ifndef MSCR_CFG_SVH
`define MSCR_CFG_SVH

// Register indices; byte address is four times the index
`define MSCR_IDX_STARTUP    8'h86
`define MSCR_IDX_CLOSED     8'h88
`define MSCR_IDX_CAP_SRC    8'h8c
`define MSCR_RST_STARTUP    32'h0000_0000
`define MSCR_RST_CLOSED     32'h0000_0000
`define MSCR_RST_CAP_SRC    32'h0000_0000
// Writable bits; bit 31 of all three words is reserved
`define MSCR_WMASK_STARTUP  32'h7fff_ffff
`define MSCR_WMASK_CLOSED   32'h7fff_ffff
`define MSCR_WMASK_CAP_SRC  32'h0000_0001

// Field positions
`define MSCR_OLCAP_HI       30
`define MSCR_OLCAP_LO       27
`define MSCR_LACC_HI        26
`define MSCR_LACC_LO        23
`define MSCR_QACC_HI        22
`define MSCR_QACC_LO        19
`define MSCR_AUTO_BIT       18
`define MSCR_THR_HI         17
`define MSCR_THR_LO         13
`define MSCR_ALIGN_HI       12
`define MSCR_ALIGN_LO       8
`define MSCR_ICR_HI         7
`define MSCR_ICR_LO         4
`define MSCR_ICRSEL_BIT     3
`define MSCR_RAMP_HI        2
`define MSCR_RAMP_LO        0
`define MSCR_OVM_BIT        30
`define MSCR_CAPSRC_BIT     0
// First reserved alignment code
`define MSCR_ALIGN_RSV      5'h1e
`define MSCR_RESP_OKAY      2'h0
`define MSCR_RESP_SLVERR    2'h2

`endif

// ### mscr_pkg.sv
package mscr_pkg;
  // Register selected by an access
  typedef enum {MSCR_SEL_STARTUP, MSCR_SEL_CLOSED, MSCR_SEL_CAP_SRC, MSCR_SEL_NONE} mscr_sel_type;
  // Write channel progress
  typedef enum {MSCR_W_IDLE, MSCR_W_RESP} mscr_wstate_type;
endpackage : mscr_pkg

// ### mscr_regs.sv
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "mscr_cfg.svh"
module mscr_regs
  import mscr_pkg::*;
(
  // Clock, reset and enable
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        clk_en,
  // AXI4-Lite write address and data
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Controller inputs
  input  wire logic [3:0]  general_current_cap,
  input  wire logic [9:0]  open_speed_permille,
  input  wire logic        auto_handoff_ready,
  // Start-up settings, handoff request and closed-loop overmodulation enable to the controller
  output logic [3:0]       open_phase_current_cap,
  output logic [3:0]       open_phase_linear_accel,
  output logic [3:0]       open_phase_quadratic_accel,
  output logic             auto_handoff_en,
  output logic [9:0]       loop_switch_threshold,
  output logic [4:0]       align_angle_code,
  output logic             align_angle_reserved,
  output logic [9:0]       initial_cycle_rate,
  output logic [2:0]       theta_ramp_rate,
  output logic             loop_switch,
  output logic             overmodulation_en
);

  logic [31:0]     startup_q;
  logic [31:0]     closed_q;
  logic [31:0]     cap_src_q;
  logic [11:0]     awaddr_q;
  logic            aw_have_q;
  logic [31:0]     wdata_q;
  logic [3:0]      wstrb_q;
  logic            w_have_q;
  mscr_wstate_type wstate_q;
  logic [31:0]     bmask;
  logic [31:0]     wmerged;
  mscr_sel_type    wsel;
  mscr_sel_type    rsel;
  logic [9:0]      thr_d;
  logic [9:0]      icr_d;
  logic [4:0]      thr_code;
  logic [3:0]      icr_code;

  // Address decode; only aligned words of mapped indices answer OKAY
  function automatic mscr_sel_type decode(input logic [11:0] a);
    mscr_sel_type s;
    s = MSCR_SEL_NONE;
    if (a[1:0] == 2'h0) begin
      if (a[9:2] == `MSCR_IDX_STARTUP && a[11:10] == 2'h0) s = MSCR_SEL_STARTUP;
      if (a[9:2] == `MSCR_IDX_CLOSED && a[11:10] == 2'h0) s = MSCR_SEL_CLOSED;
      if (a[9:2] == `MSCR_IDX_CAP_SRC && a[11:10] == 2'h0) s = MSCR_SEL_CAP_SRC;
    end
    return s;
  endfunction : decode

  // Byte lanes expand to a bit mask
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      bmask[i*8 +: 8] = {8{wstrb_q[i]}};
    end
  end

  assign wsel          = decode(awaddr_q);
  assign rsel          = decode(s_axi_araddr);
  // Ready stays low while frozen, so no item is taken at an edge that stores nothing
  assign s_axi_awready = clk_en && !aw_have_q && wstate_q == MSCR_W_IDLE;
  assign s_axi_wready  = clk_en && !w_have_q && wstate_q == MSCR_W_IDLE;
  assign s_axi_arready = clk_en && !s_axi_rvalid;

  // Write address is latched on its own, so address and data may come in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      awaddr_q  <= 12'h000;
    end else if (clk_en) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end else if (aw_have_q && w_have_q) begin
        aw_have_q <= 1'b0;
      end
    end
  end

  // Write data and strobes are latched on their own
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have_q <= 1'b0;
      wdata_q  <= 32'h0000_0000;
      wstrb_q  <= 4'h0;
    end else if (clk_en) begin
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end else if (aw_have_q && w_have_q) begin
        w_have_q <= 1'b0;
      end
    end
  end

  // Response follows once both halves are in
  // A refused address still answers, so the master never hangs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wstate_q     <= MSCR_W_IDLE;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `MSCR_RESP_OKAY;
    end else if (clk_en) begin
      case (wstate_q)
        MSCR_W_IDLE: begin
          if (aw_have_q && w_have_q) begin
            wstate_q     <= MSCR_W_RESP;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (wsel == MSCR_SEL_NONE) ? `MSCR_RESP_SLVERR : `MSCR_RESP_OKAY;
          end
        end
        MSCR_W_RESP: begin
          if (s_axi_bready) begin
            wstate_q     <= MSCR_W_IDLE;
            s_axi_bvalid <= 1'b0;
          end
        end
        default: begin
          wstate_q     <= MSCR_W_IDLE;
          s_axi_bvalid <= 1'b0;
        end
      endcase
    end
  end

  // Only lanes with a strobe change
  assign wmerged = wdata_q & bmask;

  // Register storage; reserved bits never take a one
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      startup_q <= `MSCR_RST_STARTUP;
      closed_q  <= `MSCR_RST_CLOSED;
      cap_src_q <= `MSCR_RST_CAP_SRC;
    end else if (clk_en && aw_have_q && w_have_q && wstate_q == MSCR_W_IDLE) begin
      if (wsel == MSCR_SEL_STARTUP) begin
        startup_q <= ((startup_q & ~bmask) | wmerged) & `MSCR_WMASK_STARTUP;
      end
      if (wsel == MSCR_SEL_CLOSED) begin
        closed_q <= ((closed_q & ~bmask) | wmerged) & `MSCR_WMASK_CLOSED;
      end
      if (wsel == MSCR_SEL_CAP_SRC) begin
        cap_src_q <= ((cap_src_q & ~bmask) | wmerged) & `MSCR_WMASK_CAP_SRC;
      end
    end
  end

  // Read answer stands until rready; arready stays low meanwhile, one read at a time
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
    end else if (clk_en) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Read data is captured at the same edge that takes the address; unmapped reads give zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `MSCR_RESP_OKAY;
    end else if (clk_en && s_axi_arvalid && s_axi_arready) begin
      s_axi_rresp <= `MSCR_RESP_OKAY;
      case (rsel)
        MSCR_SEL_STARTUP: s_axi_rdata <= startup_q;
        MSCR_SEL_CLOSED:  s_axi_rdata <= closed_q;
        MSCR_SEL_CAP_SRC: s_axi_rdata <= cap_src_q;
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `MSCR_RESP_SLVERR;
        end
      endcase
    end
  end

  assign thr_code = startup_q[`MSCR_THR_HI:`MSCR_THR_LO];
  assign icr_code = startup_q[`MSCR_ICR_HI:`MSCR_ICR_LO];

  // Threshold in tenths of a percent; a table avoids width games in the arithmetic
  always_comb begin
    case (thr_code)
      5'h00:   thr_d = 10'h00a;
      5'h01:   thr_d = 10'h014;
      5'h02:   thr_d = 10'h01e;
      5'h03:   thr_d = 10'h028;
      5'h04:   thr_d = 10'h032;
      5'h05:   thr_d = 10'h03c;
      5'h06:   thr_d = 10'h046;
      5'h07:   thr_d = 10'h050;
      5'h08:   thr_d = 10'h05a;
      5'h09:   thr_d = 10'h064;
      5'h0a:   thr_d = 10'h06e;
      5'h0b:   thr_d = 10'h078;
      5'h0c:   thr_d = 10'h082;
      5'h0d:   thr_d = 10'h08c;
      5'h0e:   thr_d = 10'h096;
      5'h0f:   thr_d = 10'h0a0;
      5'h10:   thr_d = 10'h0aa;
      5'h11:   thr_d = 10'h0b4;
      5'h12:   thr_d = 10'h0be;
      5'h13:   thr_d = 10'h0c8;
      5'h14:   thr_d = 10'h0e1;
      5'h15:   thr_d = 10'h0fa;
      5'h16:   thr_d = 10'h113;
      5'h17:   thr_d = 10'h12c;
      5'h18:   thr_d = 10'h145;
      5'h19:   thr_d = 10'h15e;
      5'h1a:   thr_d = 10'h177;
      5'h1b:   thr_d = 10'h190;
      5'h1c:   thr_d = 10'h1a9;
      5'h1d:   thr_d = 10'h1c2;
      5'h1e:   thr_d = 10'h1db;
      default: thr_d = 10'h1f4;
    endcase
  end

  // First-cycle frequency in tenths of a percent
  always_comb begin
    case (icr_code)
      4'h0:    icr_d = 10'h00a;
      4'h1:    icr_d = 10'h014;
      4'h2:    icr_d = 10'h01e;
      4'h3:    icr_d = 10'h032;
      4'h4:    icr_d = 10'h04b;
      4'h5:    icr_d = 10'h064;
      4'h6:    icr_d = 10'h07d;
      4'h7:    icr_d = 10'h096;
      4'h8:    icr_d = 10'h0af;
      4'h9:    icr_d = 10'h0c8;
      4'ha:    icr_d = 10'h0fa;
      4'hb:    icr_d = 10'h12c;
      4'hc:    icr_d = 10'h15e;
      4'hd:    icr_d = 10'h190;
      4'he:    icr_d = 10'h1c2;
      default: icr_d = 10'h1f4;
    endcase
    if (!startup_q[`MSCR_ICRSEL_BIT]) icr_d = 10'h000;
  end

  // Effective open-loop cap; source select one hands the general cap through instead
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      open_phase_current_cap <= 4'h0;
    end else if (clk_en) begin
      open_phase_current_cap <= cap_src_q[`MSCR_CAPSRC_BIT] ? general_current_cap
                                : startup_q[`MSCR_OLCAP_HI:`MSCR_OLCAP_LO];
    end
  end

  // Acceleration codes pass straight through; the controller owns the rate tables
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      open_phase_linear_accel    <= 4'h0;
      open_phase_quadratic_accel <= 4'h0;
    end else if (clk_en) begin
      open_phase_linear_accel    <= startup_q[`MSCR_LACC_HI:`MSCR_LACC_LO];
      open_phase_quadratic_accel <= startup_q[`MSCR_QACC_HI:`MSCR_QACC_LO];
    end
  end

  // Handoff mode and threshold, registered so they never glitch
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      auto_handoff_en       <= 1'b0;
      loop_switch_threshold <= 10'h00a;
    end else if (clk_en) begin
      auto_handoff_en       <= startup_q[`MSCR_AUTO_BIT];
      loop_switch_threshold <= thr_d;
    end
  end

  // Alignment angle; reserved codes are flagged, not clipped
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      align_angle_code     <= 5'h00;
      align_angle_reserved <= 1'b0;
    end else if (clk_en) begin
      align_angle_code     <= startup_q[`MSCR_ALIGN_HI:`MSCR_ALIGN_LO];
      align_angle_reserved <= startup_q[`MSCR_ALIGN_HI:`MSCR_ALIGN_LO] >= `MSCR_ALIGN_RSV;
    end
  end

  // First-cycle rate and theta ramp code
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      initial_cycle_rate <= 10'h000;
      theta_ramp_rate    <= 3'h0;
    end else if (clk_en) begin
      initial_cycle_rate <= icr_d;
      theta_ramp_rate    <= startup_q[`MSCR_RAMP_HI:`MSCR_RAMP_LO];
    end
  end

  // Overmodulation enable from the closed-loop word
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      overmodulation_en <= 1'b0;
    end else if (clk_en) begin
      overmodulation_en <= closed_q[`MSCR_OVM_BIT];
    end
  end

  // Handoff request; compares against the live threshold, not the delayed copy
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      loop_switch <= 1'b0;
    end else if (clk_en) begin
      if (startup_q[`MSCR_AUTO_BIT]) begin
        loop_switch <= auto_handoff_ready;
      end else begin
        loop_switch <= open_speed_permille >= thr_d;
      end
    end
  end

endmodule : mscr_regs

// ### mscr_regs_props.sv
`timescale 1ns/1ps
module mscr_regs_chk (
  // Clock, reset and enable
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        clk_en,
  // Bus handshakes
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  // Controller side
  input wire logic [9:0]  open_speed_permille,
  input wire logic        auto_handoff_en,
  input wire logic [9:0]  loop_switch_threshold,
  input wire logic [4:0]  align_angle_code,
  input wire logic        align_angle_reserved,
  input wire logic [9:0]  initial_cycle_rate,
  input wire logic        loop_switch
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Threshold held across the edge, so register and output agree
  sequence s_manual;
    clk_en && !auto_handoff_en ##1 $stable(loop_switch_threshold) && !auto_handoff_en;
  endsequence
  chk_manual_handoff: assert property (s_manual |->
    loop_switch == ($past(open_speed_permille) >= loop_switch_threshold))
    else $error("speed handoff wrong");
  chk_read_latency: assert property (clk_en && s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  chk_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
  chk_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
  chk_rsv_bit: assert property (s_axi_rvalid |-> !s_axi_rdata[31])
    else $error("reserved bit set");
  chk_thr_table: assert property ((loop_switch_threshold inside {[10:200]} &&
    loop_switch_threshold % 10 == 0) || (loop_switch_threshold inside {[225:500]} &&
    (loop_switch_threshold - 10'd200) % 25 == 0)) else $error("threshold off table");
  chk_icr_table: assert property (initial_cycle_rate inside {0, 10, 20, 30, 50, 75,
    100, 125, 150, 175, 200, 250, 300, 350, 400, 450, 500}) else $error("first rate off table");
  chk_align_rsv: assert property (align_angle_reserved == (align_angle_code >= 5'h1e))
    else $error("align reserved flag wrong");
  chk_freeze_hold: assert property (!clk_en |=> $stable(loop_switch))
    else $error("handoff moved while frozen");
endmodule : mscr_regs_chk

bind mscr_regs mscr_regs_chk u_chk (.aclk, .aresetn, .clk_en, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rdata, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
  .open_speed_permille, .auto_handoff_en, .loop_switch_threshold, .align_angle_code,
  .align_angle_reserved, .initial_cycle_rate, .loop_switch);

// ### motor_startup_config_regs_tb_top.sv
`timescale 1ns/1ps
`include "mscr_cfg.svh"
module motor_startup_config_regs_tb_top;
  // Bus and controller signals, connected by name
  logic        aclk, aresetn, clk_en, auto_handoff_ready, loop_switch, overmodulation_en;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        auto_handoff_en, align_angle_reserved;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [2:0]  theta_ramp_rate;
  logic [3:0]  s_axi_wstrb, general_current_cap, open_phase_current_cap;
  logic [3:0]  open_phase_linear_accel, open_phase_quadratic_accel;
  logic [4:0]  align_angle_code;
  logic [9:0]  open_speed_permille, loop_switch_threshold, initial_cycle_rate;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  int          n_errors, samples_checked, cycles;
  // Byte addresses are four times the register index
  localparam logic [11:0] a_su = {2'h0, `MSCR_IDX_STARTUP, 2'h0};
  localparam logic [11:0] a_cl = {2'h0, `MSCR_IDX_CLOSED, 2'h0};
  localparam logic [11:0] a_cs = {2'h0, `MSCR_IDX_CAP_SRC, 2'h0};
  localparam int icr_tab [16] = '{10, 20, 30, 50, 75, 100, 125, 150, 175, 200, 250, 300,
    350, 400, 450, 500};

  mscr_regs dut (.*);

  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  task automatic give_verdict;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  // Address and data offered together; ready for the answer is held high throughout
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    check("bresp", s_axi_bresp, er);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    check("rdata", s_axi_rdata, ed);
    check("rresp", s_axi_rresp, er);
  endtask : rd

  // Settings outputs lag the register by one edge
  task automatic settle;
    repeat (3) @(posedge aclk);
  endtask : settle

  // Hang guard, well above the few hundred cycles the run needs
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      give_verdict();
    end
  end

  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, auto_handoff_ready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, open_speed_permille} = '0;
    {clk_en, s_axi_bready, s_axi_rready} = 3'h7;
    s_axi_wstrb = 4'hf;
    general_current_cap = 4'h5;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(a_su, 32'h0, `MSCR_RESP_OKAY);
    rd(a_cl, 32'h0, `MSCR_RESP_OKAY);
    check("thr", loop_switch_threshold, 10);
    check("ovm", overmodulation_en, 0);
    // All ones: every field at its top code
    wr(a_su, 32'hffff_ffff, `MSCR_RESP_OKAY);
    settle;
    rd(a_su, 32'h7fff_ffff, `MSCR_RESP_OKAY);
    check("cap", open_phase_current_cap, 4'hf);
    check("acc", {open_phase_linear_accel, open_phase_quadratic_accel}, 8'hff);
    check("ramp", theta_ramp_rate, 3'h7);
    check("auto", auto_handoff_en, 1);
    auto_handoff_ready <= 1'b1;
    settle;
    check("lsw", loop_switch, 1);
    // Sweep every threshold and angle code, first-cycle select toggling
    for (int c = 0; c < 32; c++) begin
      wr(a_su, {14'h0, c[4:0], c[4:0], c[3:0], c[0], 3'h0}, `MSCR_RESP_OKAY);
      settle;
      check("thr", loop_switch_threshold, c < 20 ? (c + 1) * 10 : 200 + (c - 19) * 25);
      check("icr", initial_cycle_rate, c[0] ? icr_tab[c % 16] : 0);
      check("arsv", align_angle_reserved, c >= 30);
      check("angle", align_angle_code, c[4:0]);
    end
    // Manual handoff at exactly the 5% threshold
    wr(a_su, {14'h0, 5'h04, 13'h0}, `MSCR_RESP_OKAY);
    open_speed_permille <= 10'd49;
    settle;
    check("lsw", loop_switch, 0);
    open_speed_permille <= 10'd50;
    settle;
    check("lsw", loop_switch, 1);
    // Clock enable low freezes state and refuses reads
    clk_en <= 1'b0;
    open_speed_permille <= 10'd0;
    settle;
    check("lsw", loop_switch, 1);
    check("arrdy", s_axi_arready, 0);
    clk_en <= 1'b1;
    settle;
    check("lsw", loop_switch, 0);
    // Cap source select
    wr(a_su, 32'h5000_0000, `MSCR_RESP_OKAY);
    wr(a_cs, 32'hffff_ffff, `MSCR_RESP_OKAY);
    settle;
    check("cap", open_phase_current_cap, 4'h5);
    rd(a_cs, 32'h1, `MSCR_RESP_OKAY);
    wr(a_cs, 32'h0, `MSCR_RESP_OKAY);
    settle;
    check("cap", open_phase_current_cap, 4'ha);
    // Closed-loop word
    wr(a_cl, 32'hffff_ffff, `MSCR_RESP_OKAY);
    settle;
    rd(a_cl, 32'h7fff_ffff, `MSCR_RESP_OKAY);
    check("ovm", overmodulation_en, 1);
    wr(a_cl, 32'hbfff_ffff, `MSCR_RESP_OKAY);
    settle;
    check("ovm", overmodulation_en, 0);
    // Unmapped and unaligned places are refused
    wr(12'h224, 32'hffff_ffff, `MSCR_RESP_SLVERR);
    rd(12'h224, 32'h0, `MSCR_RESP_SLVERR);
    rd(12'h219, 32'h0, `MSCR_RESP_SLVERR);
    // Reset again mid-run: both words and the outputs return to defaults
    aresetn <= 1'b0;
    settle;
    aresetn <= 1'b1;
    @(posedge aclk);
    check("thr", loop_switch_threshold, 10);
    check("ovm", overmodulation_en, 0);
    rd(a_cl, 32'h0, `MSCR_RESP_OKAY);
    rd(a_su, 32'h0, `MSCR_RESP_OKAY);
    give_verdict();
  end
endmodule : motor_startup_config_regs_tb_top
